/* gspb_pkg.sv */
// Purpose: Shared constants, types and helpers of the general serial port buffer.
// Assumes: 100 MHz controller clock, 16-bit word memory, 16-bit register port.
// Notes:   Register addresses are word indices on the register port.
package gspb_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TX_MAX_BYTES = 2048;
  localparam int unsigned RX_MAX_BYTES = 4096;
  localparam int unsigned BAUD_RATE [0:7] = '{2400, 4800, 9600, 19200, 38400, 57600, 115200, 115200};

  localparam logic [2:0] ADR_CTRL   = 3'h0;
  localparam logic [2:0] ADR_RXBASE = 3'h1;
  localparam logic [2:0] ADR_RXCAP  = 3'h2;
  localparam logic [2:0] ADR_TXBASE = 3'h3;
  localparam logic [2:0] ADR_TXCMD  = 3'h4;
  localparam logic [2:0] ADR_STATUS = 3'h5;
  localparam logic [2:0] ADR_RXCNT  = 3'h6;

  localparam logic [1:0] PAR_NONE  = 2'h0;
  localparam logic [1:0] PAR_ODD   = 2'h1;
  localparam logic [1:0] PAR_EVEN  = 2'h2;
  localparam logic [1:0] TERM_CR   = 2'h0;
  localparam logic [1:0] TERM_CRLF = 2'h1;
  localparam logic [1:0] TERM_NONE = 2'h2;
  localparam logic [1:0] TERM_ETX  = 2'h3;

  localparam logic [7:0] CODE_STX = 8'h02;
  localparam logic [7:0] CODE_ETX = 8'h03;
  localparam logic [7:0] CODE_CR  = 8'h0D;
  localparam logic [7:0] CODE_LF  = 8'h0A;

  // Control word: bit 0 mode, 1 data length 8, 3:2 parity, 4 two stops, 6:5 terminator, 7 header, 10:8 rate
  typedef struct packed {
    logic [4:0] rsv;
    logic [2:0] baud;
    logic       hdr;
    logic [1:0] term;
    logic       stop2;
    logic [1:0] par;
    logic       dlen8;
    logic       mode_gp;
  } gspb_ctrl_type;

  localparam logic [15:0] CTRL_RESET   = 16'h0206;
  localparam logic [15:0] RXBASE_RESET = 16'h0000;
  localparam logic [11:0] RXCAP_RESET  = 12'h800;

  localparam logic [2:0] PH_HDR  = 3'h0;
  localparam logic [2:0] PH_DATA = 3'h1;
  localparam logic [2:0] PH_T1   = 3'h2;
  localparam logic [2:0] PH_T2   = 3'h3;
  localparam logic [2:0] PH_FIN  = 3'h4;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_TX_LD  = 9'h002,
    ST_TX_NXT = 9'h004,
    ST_TX_RD  = 9'h008,
    ST_TX_RW1 = 9'h010,
    ST_TX_RW2 = 9'h020,
    ST_TX_FIN = 9'h040,
    ST_RX_CNT = 9'h080,
    ST_CLR    = 9'h100
  } gspb_st_type;

  function automatic logic [15:0] gspb_div(input logic [2:0] idx);
    gspb_div = 16'(CLK_HZ / BAUD_RATE[idx]);
  endfunction

endpackage

/* gspb_port.sv */
// Purpose: One general-purpose serial port moving send tables and receive areas in word memory.
// Assumes: Word memory answers a read in the cycle after MEM_RE; writes honour MEM_BE.
// Notes:   Instantiate once per port; each instance keeps its own settings.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
module gspb_port
  import gspb_pkg::*;
#(
  parameter bit USE_CTS = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic [2:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR_STB,
  input  wire logic        RD_STB,
  output logic      [15:0] RDATA,
  output logic      [15:0] MEM_ADDR,
  output logic      [15:0] MEM_WDATA,
  output logic      [1:0]  MEM_BE,
  output logic             MEM_WE,
  output logic             MEM_RE,
  input  wire logic [15:0] MEM_RDATA,
  output logic             TXD,
  input  wire logic        RXD,
  input  wire logic        CTS,
  input  wire logic        RUN,
  output logic             TX_DONE_FLAG,
  output logic             RX_DONE_FLAG,
  output logic             RX_ERROR_FLAG
);

  typedef struct packed {
    gspb_st_type   st;
    gspb_ctrl_type ctrl;
    logic [15:0]   rxbase;
    logic [11:0]   rxcap;
    logic [15:0]   txbase;
    logic [15:0]   txreq;
    logic [11:0]   txmag;
    logic          txneg;
    logic [11:0]   txidx;
    logic [15:0]   txword;
    logic          txhave;
    logic [2:0]    phase;
    logic          txgo;
    logic          clrpend;
    logic          tx_done;
    logic          rx_done;
    logic          rx_err;
    logic [12:0]   rxcnt;
    logic          crpend;
    logic [7:0]    rxbyte;
    logic          rxpend;
    logic          run;
    logic [15:0]   rd;
    logic [15:0]   mem_addr;
    logic [15:0]   mem_wdata;
    logic [1:0]    mem_be;
    logic          mem_we;
    logic          mem_re;
    logic [11:0]   tframe;
    logic [3:0]    tnb;
    logic [15:0]   tdiv;
    logic          tbusy;
    logic          txd;
    logic [11:0]   rframe;
    logic [3:0]    rbit;
    logic [15:0]   rdiv;
    logic          rbusy;
    logic          rxd_prev;
  } gspb_port_type;

  gspb_port_type q;
  gspb_port_type n;

  logic [15:0] div;
  logic [3:0]  nb;
  logic        cts_ok;
  logic        cmd_wr;
  logic [15:0] mag16;
  logic        rx_en;
  logic [12:0] rx_lim;

  // Character layout on the line, start bit at index 0
  function automatic logic [11:0] gspb_frame(input logic [7:0] b, input gspb_ctrl_type c);
    logic [11:0] f;
    logic [3:0]  pos;
    logic        p;
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 7 || c.dlen8) begin
        f[i + 1] = b[i];
      end
    end
    p = c.dlen8 ? ^b : ^b[6:0];
    pos = c.dlen8 ? 4'h9 : 4'h8;
    if (c.par != PAR_NONE) begin
      f[pos] = (c.par == PAR_ODD) ? ~p : p;
    end
    return f;
  endfunction

  // Returns error bit above the data byte
  function automatic logic [8:0] gspb_check(input logic [11:0] r, input gspb_ctrl_type c);
    logic [7:0] d;
    logic [3:0] pos;
    logic       bad;
    d = c.dlen8 ? r[8:1] : {1'b0, r[7:1]};
    pos = c.dlen8 ? 4'h9 : 4'h8;
    bad = r[0];
    if (c.par != PAR_NONE) begin
      bad = bad | (r[pos] != ((c.par == PAR_ODD) ? ~^d : ^d));
      pos = 4'(pos + 4'h1);
    end
    bad = bad | ~r[pos];
    if (c.stop2) begin
      bad = bad | ~r[4'(pos + 4'h1)];
    end
    return {bad, d};
  endfunction

  assign div    = gspb_div(q.ctrl.baud);
  // Start, seven data bits and one stop make the base of nine line bits
  assign nb     = 4'(4'h2 + {3'h0, q.ctrl.dlen8} + 4'h7 + {3'h0, q.ctrl.par != PAR_NONE} + {3'h0, q.ctrl.stop2});
  assign cts_ok = !USE_CTS || CTS;
  assign cmd_wr = WR_STB && ADDR == ADR_TXCMD && q.ctrl.mode_gp;
  assign mag16  = WDATA[15] ? 16'(~WDATA + 16'h0001) : WDATA;
  // Reception shut while sending keeps the link half duplex
  assign rx_en  = q.ctrl.mode_gp && !q.rx_done && !q.rx_err && q.tx_done && !q.tbusy;
  assign rx_lim = (q.rxcap == 12'h000) ? 13'h0000 : 13'({q.rxcap - 12'h001, 1'b0});

  always_comb begin
    logic       start;
    logic [7:0] sbyte;
    logic [8:0] chk;
    start = 1'b0;
    sbyte = 8'h00;
    chk = 9'h000;
    n = q;
    n.mem_we = 1'b0;
    n.mem_re = 1'b0;
    n.rd = 16'h0000;
    n.run = RUN;
    n.rxd_prev = RXD;

    // Register port
    if (RD_STB) begin
      case (ADDR)
        ADR_CTRL:   n.rd = q.ctrl;
        ADR_RXBASE: n.rd = q.rxbase;
        ADR_RXCAP:  n.rd = {4'h0, q.rxcap};
        ADR_TXBASE: n.rd = q.txbase;
        ADR_TXCMD:  n.rd = q.txreq;
        ADR_STATUS: n.rd = {12'h000, q.ctrl.mode_gp, q.rx_err, q.rx_done, q.tx_done};
        ADR_RXCNT:  n.rd = {3'h0, q.rxcnt};
        default:    n.rd = 16'h0000;
      endcase
    end
    if (WR_STB) begin
      case (ADDR)
        ADR_CTRL:   n.ctrl = {5'h00, WDATA[10:0]};
        ADR_RXBASE: n.rxbase = WDATA;
        ADR_RXCAP:  n.rxcap = WDATA[11:0];
        ADR_TXBASE: n.txbase = WDATA;
        default:    n.rd = n.rd;
      endcase
    end
    if (cmd_wr) begin
      if (WDATA == 16'h0000) begin
        n.rx_done = 1'b0;
        n.rx_err = 1'b0;
        n.rxcnt = 13'h0000;
        n.crpend = 1'b0;
        n.clrpend = 1'b1;
      end else if (q.tx_done && !q.txgo && mag16 <= 16'(TX_MAX_BYTES)) begin
        n.txreq = WDATA;
        n.txmag = mag16[11:0];
        n.txneg = WDATA[15];
        n.tx_done = 1'b0;
        n.rx_done = 1'b0;
        n.rx_err = 1'b0;
        n.rxcnt = 13'h0000;
        n.crpend = 1'b0;
        n.clrpend = 1'b1;
        n.txgo = 1'b1;
      end
    end
    if (RUN && !q.run) begin
      n.rx_done = 1'b0;
    end

    case (q.st)
      ST_IDLE: begin
        if (q.clrpend) begin
          n.clrpend = 1'b0;
          n.st = ST_CLR;
          n.mem_addr = q.rxbase;
          n.mem_wdata = 16'h0000;
          n.mem_be = 2'h3;
          n.mem_we = 1'b1;
        end else if (q.txgo) begin
          n.txgo = 1'b0;
          n.st = ST_TX_LD;
          n.mem_addr = q.txbase;
          n.mem_wdata = q.txreq;
          n.mem_be = 2'h3;
          n.mem_we = 1'b1;
          n.txidx = 12'h000;
          n.txhave = 1'b0;
          n.phase = PH_HDR;
        end else if (q.rxpend && !cmd_wr) begin
          // Deferred on a request cycle so a terminator set lands after the clear
          n.rxpend = 1'b0;
          if (q.rx_done || q.rx_err || !q.ctrl.mode_gp) begin
            n.rxpend = 1'b0;
          end else if (q.ctrl.hdr && q.rxbyte == CODE_STX) begin
            n.rxcnt = 13'h0000;
            n.crpend = 1'b0;
            n.st = ST_CLR;
            n.mem_addr = q.rxbase;
            n.mem_wdata = 16'h0000;
            n.mem_be = 2'h3;
            n.mem_we = 1'b1;
          end else if ((q.ctrl.term == TERM_CR && q.rxbyte == CODE_CR) ||
                       (q.ctrl.term == TERM_ETX && q.rxbyte == CODE_ETX) ||
                       (q.ctrl.term == TERM_CRLF && q.rxbyte == CODE_LF && q.crpend)) begin
            n.rx_done = 1'b1;
            n.crpend = 1'b0;
          end else if (q.ctrl.term == TERM_CRLF && q.rxbyte == CODE_CR) begin
            n.crpend = 1'b1;
          end else if (q.rxcnt < 13'(RX_MAX_BYTES) && q.rxcnt < rx_lim) begin
            n.crpend = 1'b0;
            n.mem_addr = 16'(q.rxbase + 16'h0001 + 16'(q.rxcnt[12:1]));
            n.mem_wdata = {q.rxbyte, q.rxbyte};
            n.mem_be = q.rxcnt[0] ? 2'h2 : 2'h1;
            n.mem_we = 1'b1;
            n.rxcnt = 13'(q.rxcnt + 13'h0001);
            n.st = ST_RX_CNT;
          end
        end
      end
      ST_RX_CNT: begin
        n.mem_addr = q.rxbase;
        n.mem_wdata = {3'h0, q.rxcnt};
        n.mem_be = 2'h3;
        n.mem_we = 1'b1;
        n.st = ST_CLR;
      end
      ST_CLR: n.st = ST_IDLE;
      ST_TX_LD: n.st = ST_TX_NXT;
      ST_TX_NXT: begin
        // A frame already being received finishes before the first character goes out
        if (!q.tbusy && !q.rbusy) begin
          case (q.phase)
            PH_HDR: begin
              if (!q.ctrl.hdr) begin
                n.phase = PH_DATA;
              end else if (cts_ok) begin
                start = 1'b1;
                sbyte = CODE_STX;
                n.phase = PH_DATA;
              end
            end
            PH_DATA: begin
              if (q.txidx == q.txmag) begin
                n.phase = PH_T1;
              end else if (!q.txidx[0] && !q.txhave) begin
                n.mem_addr = 16'(q.txbase + 16'h0001 + 16'(q.txidx[11:1]));
                n.mem_re = 1'b1;
                n.st = ST_TX_RD;
              end else if (cts_ok) begin
                start = 1'b1;
                sbyte = q.txidx[0] ? q.txword[15:8] : q.txword[7:0];
                n.txhave = !q.txidx[0];
                n.txidx = 12'(q.txidx + 12'h001);
              end
            end
            PH_T1: begin
              if (q.txneg || q.ctrl.term == TERM_NONE) begin
                n.phase = PH_FIN;
              end else if (cts_ok) begin
                start = 1'b1;
                sbyte = (q.ctrl.term == TERM_ETX) ? CODE_ETX : CODE_CR;
                n.phase = (q.ctrl.term == TERM_CRLF) ? PH_T2 : PH_FIN;
              end
            end
            PH_T2: begin
              if (cts_ok) begin
                start = 1'b1;
                sbyte = CODE_LF;
                n.phase = PH_FIN;
              end
            end
            default: begin
              n.mem_addr = q.txbase;
              n.mem_wdata = 16'h0000;
              n.mem_be = 2'h3;
              n.mem_we = 1'b1;
              n.st = ST_TX_FIN;
            end
          endcase
        end
      end
      ST_TX_RD: n.st = ST_TX_RW1;
      ST_TX_RW1: n.st = ST_TX_RW2;
      ST_TX_RW2: begin
        n.txword = MEM_RDATA;
        n.txhave = 1'b1;
        n.st = ST_TX_NXT;
      end
      ST_TX_FIN: begin
        n.tx_done = 1'b1;
        n.st = ST_IDLE;
      end
      default: n.st = ST_IDLE;
    endcase

    // Transmit shifter
    if (start) begin
      n.tframe = gspb_frame(sbyte, q.ctrl);
      n.txd = 1'b0;
      n.tnb = 4'h0;
      n.tdiv = 16'(div - 16'h0001);
      n.tbusy = 1'b1;
    end else if (q.tbusy) begin
      if (q.tdiv == 16'h0000) begin
        n.tnb = 4'(q.tnb + 4'h1);
        n.tdiv = 16'(div - 16'h0001);
        if (4'(q.tnb + 4'h1) == nb) begin
          n.tbusy = 1'b0;
          n.txd = 1'b1;
        end else begin
          n.txd = q.tframe[4'(q.tnb + 4'h1)];
        end
      end else begin
        n.tdiv = 16'(q.tdiv - 16'h0001);
      end
    end

    // Receive sampler, centre of each bit
    if (!q.rbusy) begin
      if (rx_en && q.rxd_prev && !RXD) begin
        n.rbusy = 1'b1;
        n.rbit = 4'h0;
        n.rdiv = {1'b0, div[15:1]};
      end
    end else if (q.rdiv != 16'h0000) begin
      n.rdiv = 16'(q.rdiv - 16'h0001);
    end else begin
      n.rframe[q.rbit] = RXD;
      n.rdiv = 16'(div - 16'h0001);
      n.rbit = 4'(q.rbit + 4'h1);
      if (q.rbit == 4'h0 && RXD) begin
        n.rbusy = 1'b0;
      end else if (4'(q.rbit + 4'h1) == nb) begin
        n.rbusy = 1'b0;
        chk = gspb_check(n.rframe, q.ctrl);
        if (chk[8]) begin
          n.rx_err = 1'b1;
        end else begin
          n.rxbyte = chk[7:0];
          n.rxpend = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= CTRL_RESET;
      q.rxbase <= RXBASE_RESET;
      q.rxcap <= RXCAP_RESET;
      q.tx_done <= 1'b1;
      q.txd <= 1'b1;
      q.rxd_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign RDATA         = q.rd;
  assign MEM_ADDR      = q.mem_addr;
  assign MEM_WDATA     = q.mem_wdata;
  assign MEM_BE        = q.mem_be;
  assign MEM_WE        = q.mem_we;
  assign MEM_RE        = q.mem_re;
  assign TXD           = q.txd;
  assign TX_DONE_FLAG  = q.tx_done;
  assign RX_DONE_FLAG  = q.rx_done;
  assign RX_ERROR_FLAG = q.rx_err;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  AST_TXDONE_LOW: assert property (q.tbusy || q.st != ST_IDLE && q.st != ST_CLR && q.st != ST_RX_CNT |-> !TX_DONE_FLAG)
    else $error("transmit-done high while sending");
  AST_LOAD_COUNT: assert property (q.st == ST_TX_LD |-> MEM_WE && MEM_ADDR == q.txbase && MEM_WDATA == q.txreq)
    else $error("count word not loaded at send start");
  AST_FIN_CLEAR: assert property (q.st == ST_TX_FIN |-> MEM_WE && MEM_WDATA == 16'h0000 ##1 TX_DONE_FLAG)
    else $error("send end did not clear count and raise done");
  AST_NONE_NODONE: assert property (q.ctrl.term == TERM_NONE && $past(q.ctrl.term) == TERM_NONE |-> !$rose(RX_DONE_FLAG))
    else $error("receive done rose with no terminator");
  AST_HALF_DUPLEX: assert property (q.tbusy |-> !q.rbusy)
    else $error("send and receive overlap");
  AST_CTS_HOLD: assert property ($rose(q.tbusy) && USE_CTS |-> $past(CTS))
    else $error("character started without clear-to-send");
  AST_RX_IGNORE: assert property (RX_DONE_FLAG && !cmd_wr |=> $stable(q.rxcnt))
    else $error("count moved while receive done");
  AST_LEN_LIMIT: assert property (q.st == ST_TX_LD |-> q.txmag != 12'h000 && q.txmag <= 12'(TX_MAX_BYTES))
    else $error("send length out of range");
  AST_NEG_NOTERM: assert property (q.st == ST_TX_NXT && q.phase == PH_T1 && q.txneg |=> q.phase == PH_FIN && !$rose(q.tbusy))
    else $error("terminator sent for negative count");

  COV_SEND_DONE: cover property ($rose(TX_DONE_FLAG));
  COV_RECV_DONE: cover property ($rose(RX_DONE_FLAG));
  COV_RECV_ERR:  cover property ($rose(RX_ERROR_FLAG));
  COV_HDR_SENT:  cover property (q.st == ST_TX_NXT && q.phase == PH_HDR && q.ctrl.hdr && cts_ok && !q.tbusy);

endmodule

/* gspb_dev.sv */
// Purpose: Behavioural far-side serial device: decodes the port's output, sends bytes back.
// Assumes: 8 data bits, odd parity, 1 stop bit at the bit period given by BIT_CYC.
// Notes:   Speaks only when the bench calls send_byte, so the link stays half duplex.
`timescale 1ns/1ns
module gspb_dev
  import gspb_pkg::*;
#(
  parameter int BIT_CYC = 868
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got_q [$];
  int         frame_errs;

  function automatic logic odd_bit(input logic [7:0] b);
    odd_bit = ~^b;
  endfunction

  initial begin
    logic [7:0] b;
    logic       p;
    frame_errs = 0;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      // A start bit high at mid-bit is a glitch, not a frame
      if (txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          b[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        p = txd;
        repeat (BIT_CYC) @(posedge clk);
        if (p !== odd_bit(b) || txd !== 1'b1) begin
          frame_errs++;
        end
        got_q.push_back(b);
      end
    end
  end

  initial rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, odd_bit(b), b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
endmodule

/* tb_general_serial_port_buffer.sv */
// Purpose: Self-checking bench of one general serial port with word memory and far-side device.
// Assumes: 100 MHz clock; port run at 115200 bps to keep frames short.
// Notes:   Frames cost about 9.5k cycles each, so the scenarios use few characters.
`timescale 1ns/1ns
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin errors++; $display("MISMATCH t=%0t act=%h exp=%h", $time, (act), (exp)); end end
module tb_general_serial_port_buffer
  import gspb_pkg::*;
;
  localparam int BIT_CYC = CLK_HZ / BAUD_RATE[6];

  typedef struct packed {
    logic [2:0]  adr;
    logic [15:0] wd;
    logic [15:0] exp;
  } gspb_row_type;

  localparam gspb_row_type ROWS [0:3] = '{
    '{ADR_RXBASE, 16'h0010, 16'h0010},
    '{ADR_RXCAP,  16'h0008, 16'h0008},
    '{ADR_TXBASE, 16'h0020, 16'h0020},
    '{ADR_CTRL,   16'h0687, 16'h0687}
  };

  logic        clk       = 1'b0;
  logic        rst_b     = 1'b0;
  logic [2:0]  addr      = 3'h0;
  logic [15:0] wdata     = 16'h0000;
  logic        wr_stb    = 1'b0;
  logic        rd_stb    = 1'b0;
  logic [15:0] mem_rdata = 16'h0000;
  logic        cts       = 1'b0;
  logic        run       = 1'b0;
  logic [15:0] rdata;
  logic [15:0] mem_addr;
  logic [15:0] mem_wdata;
  logic [1:0]  mem_be;
  logic        mem_we;
  logic        mem_re;
  logic        txd;
  logic        rxd;
  logic        tx_done;
  logic        rx_done;
  logic        rx_err;
  logic [15:0] mem [0:63];
  int          errors      = 0;
  int          checks_done = 0;

  always #5 clk = ~clk;

  gspb_port #(.USE_CTS(1'b1)) u_dut (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .RDATA(rdata), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_BE(mem_be), .MEM_WE(mem_we),
    .MEM_RE(mem_re), .MEM_RDATA(mem_rdata), .TXD(txd), .RXD(rxd), .CTS(cts), .RUN(run),
    .TX_DONE_FLAG(tx_done), .RX_DONE_FLAG(rx_done), .RX_ERROR_FLAG(rx_err)
  );

  gspb_dev #(.BIT_CYC(BIT_CYC)) u_dev (
    .clk(clk),
    .txd(txd),
    .rxd(rxd)
  );

  // Word memory: read data in the cycle after the read pulse
  always @(posedge clk) begin
    if (mem_re) mem_rdata <= mem[mem_addr[5:0]];
    if (mem_we && mem_be[0]) mem[mem_addr[5:0]][7:0] <= mem_wdata[7:0];
    if (mem_we && mem_be[1]) mem[mem_addr[5:0]][15:8] <= mem_wdata[15:8];
  end

  task automatic finish_test();
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // Bounded wait; running out counts as a mismatch
  task automatic wait_tx(input int lim);
    int k;
    k = 0;
    @(posedge clk);
    while (tx_done !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (tx_done !== 1'b1) errors++;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial begin
    logic [15:0] v;
    int          k;
    for (int i = 0; i < 64; i++) mem[i] = 16'h0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    run   <= 1'b1;
    @(posedge clk);
    `CHK(tx_done, 1'b1)
    `CHK(rx_done, 1'b0)
    `CHK(txd, 1'b1)
    rd(ADR_CTRL, v);
    `CHK(v, 16'h0206)
    rd(ADR_RXCAP, v);
    `CHK(v, 16'h0800)
    rd(3'h7, v);
    `CHK(v, 16'h0000)
    // Link mode must ignore a transfer request
    wr(ADR_TXCMD, 16'h0001);
    @(posedge clk);
    `CHK(tx_done, 1'b1)
    for (int i = 0; i < 4; i++) begin
      wr(ROWS[i].adr, ROWS[i].wd);
      rd(ROWS[i].adr, v);
      `CHK(v, ROWS[i].exp)
    end
    // Header on, CR terminator, one byte, held back by clear-to-send
    mem[6'h21] = 16'h5A41;
    wr(ADR_TXCMD, 16'h0001);
    @(posedge clk);
    `CHK(tx_done, 1'b0)
    `CHK(rx_done, 1'b0)
    wr(ADR_TXCMD, 16'h0002);
    k = 0;
    repeat (1000) begin
      @(posedge clk);
      if (txd !== 1'b1) k++;
    end
    `CHK(k, 0)
    `CHK(mem[6'h20], 16'h0001)
    cts <= 1'b1;
    wait_tx(40000);
    `CHK(u_dev.got_q.size(), 3)
    `CHK(u_dev.got_q[0], CODE_STX)
    `CHK(u_dev.got_q[1], 8'h41)
    `CHK(u_dev.got_q[2], CODE_CR)
    `CHK(mem[6'h20], 16'h0000)
    `CHK(tx_done, 1'b1)
    u_dev.got_q.delete();
    // Negative count: two bytes, no terminator, header now off
    wr(ADR_CTRL, 16'h0607);
    mem[6'h21] = 16'h4443;
    @(posedge clk);
    wr(ADR_TXCMD, 16'hFFFE);
    wait_tx(30000);
    `CHK(u_dev.got_q.size(), 2)
    `CHK(u_dev.got_q[0], 8'h43)
    `CHK(u_dev.got_q[1], 8'h44)
    `CHK(u_dev.frame_errs, 0)
    wr(ADR_TXCMD, 16'h0801);
    @(posedge clk);
    `CHK(tx_done, 1'b1)
    // Receive two bytes and the terminator, then one that must be ignored
    u_dev.send_byte(8'h41);
    u_dev.send_byte(8'h42);
    u_dev.send_byte(CODE_CR);
    repeat (4) @(posedge clk);
    `CHK(mem[6'h10], 16'h0002)
    `CHK(mem[6'h11], 16'h4241)
    `CHK(mem[6'h12], 16'h0000)
    `CHK(rx_done, 1'b1)
    `CHK(rx_err, 1'b0)
    u_dev.send_byte(8'h43);
    repeat (4) @(posedge clk);
    `CHK(mem[6'h10], 16'h0002)
    `CHK(mem[6'h12], 16'h0000)
    wr(ADR_TXCMD, 16'h0000);
    repeat (4) @(posedge clk);
    `CHK(rx_done, 1'b0)
    `CHK(mem[6'h10], 16'h0000)
    `CHK(mem[6'h11], 16'h4241)
    rd(ADR_RXCNT, v);
    `CHK(v, 16'h0000)
    // No terminator: a carriage return is plain data and never completes
    wr(ADR_CTRL, 16'h0647);
    u_dev.send_byte(CODE_CR);
    repeat (4) @(posedge clk);
    `CHK(rx_done, 1'b0)
    `CHK(mem[6'h10], 16'h0001)
    `CHK(mem[6'h11], 16'h420D)
    finish_test();
  end
endmodule
